/* rtl/dmcp_pkg.sv */
// Shared constants and types of the dual mode serial control port
package dmcp_pkg;

  // ***********************************************************
  // Word layout
  // ***********************************************************
  localparam int DMCP_WORD_W = 16;
  localparam int DMCP_ADDR_W = 7;
  localparam int DMCP_DATA_W = 9;
  localparam int DMCP_BYTE_W = 8;

  // ***********************************************************
  // 2-wire device address: upper six bits fixed, lsb from pin
  // ***********************************************************
  localparam logic [5:0] DMCP_DEV_ADDR_HI = 6'h0d;
  localparam logic DMCP_DIR_WRITE = 1'b0;

  // ***********************************************************
  // Synchroniser lane positions and reset levels
  // ***********************************************************
  localparam int DMCP_SYN_W = 4;
  localparam int DMCP_SYN_SCL = 0;
  localparam int DMCP_SYN_SDA = 1;
  localparam int DMCP_SYN_SEL = 2;
  localparam int DMCP_SYN_MODE = 3;
  localparam logic [3:0] DMCP_SYN_RST = 4'h0;

  // ***********************************************************
  // Counters and reset values
  // ***********************************************************
  localparam logic [4:0] DMCP_3W_FULL = 5'h10;
  localparam logic [2:0] DMCP_LAST_BIT = 3'h7;
  localparam logic [15:0] DMCP_WORD_RST = 16'h0000;
  localparam logic [7:0] DMCP_BYTE_RST = 8'h00;

  // Decoded control word
  typedef struct packed {
    logic [6:0] addr;
    logic [8:0] data;
  } dmcp_word_t;

  // 2-wire receive sequence
  typedef enum logic [2:0] {
    DMCP_IDLE = 3'b000,
    DMCP_ADDR = 3'b001,
    DMCP_ACK_A = 3'b010,
    DMCP_BYTE1 = 3'b011,
    DMCP_ACK_1 = 3'b100,
    DMCP_BYTE2 = 3'b101,
    DMCP_ACK_2 = 3'b110,
    DMCP_WAIT_STOP = 3'b111
  } dmcp_state_t;

endpackage

/* rtl/dmcp_port.sv */
// Dual mode (2-wire / 3-wire) serial control port, slave only
//
// Behaviour
// - Every transfer carries 16 bits split into a 7-bit address on top and 9 data bits below.
// - The format strap picks 2-wire when low and 3-wire when high.
// - An open strap falls back to 2-wire, which is also the value held from reset.
// - The port is a slave only and never drives the serial clock or starts a transfer.
// - In 3-wire format bits are shifted in on the data line and applied on the latch pulse.
// - A falling data line while the clock is high starts a 2-wire sequence.
// - After a start eight bits are taken msb first, seven address bits then the direction.
// - A matching address with write direction is acknowledged by holding data low one pulse.
// - A wrong address or a read gets no acknowledge and the port returns to idle.
// - The first data byte carries word bits 15 to 8 and is acknowledged.
// - The second data byte carries word bits 7 to 0 and is acknowledged.
// - A rising data line while the clock is high ends the sequence and the port goes idle.
// - A start or stop out of sequence abandons the transfer at once.
// - The 2-wire address is 0011010 with the select pin low and 0011011 with it high.
`timescale 1ns/100ps
`default_nettype none
module dmcp_port
  import dmcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic format_sel_pin,
  input wire logic serial_clk,
  input wire logic control_data_line_i,
  output logic control_data_line_o,
  output logic control_data_line_oe,
  input wire logic select_latch_or_addr_pin,
  output dmcp_word_t word_q,
  output logic word_valid_q
);

  // ***********************************************************
  // Pin synchronisation and edge detection
  // ***********************************************************
  logic [3:0] syn;
  logic [3:0] prev_q;
  logic scl_s, sda_s, sel_s, mode_3w;
  logic scl_rise, scl_fall, start_det, stop_det, sel_rise;

  dmcp_sync2 u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({format_sel_pin, select_latch_or_addr_pin,
               control_data_line_i, serial_clk}),
    .sync_out(syn)
  );

  // Previous synchronised levels for edge finding
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= DMCP_SYN_RST;
    end else begin
      prev_q <= syn;
    end
  end

  // Strap low or unstrapped (reset value 0) means 2-wire
  assign mode_3w = syn[DMCP_SYN_MODE];
  assign scl_s = syn[DMCP_SYN_SCL];
  assign sda_s = syn[DMCP_SYN_SDA];
  assign sel_s = syn[DMCP_SYN_SEL];
  assign scl_rise = scl_s & ~prev_q[DMCP_SYN_SCL];
  assign scl_fall = ~scl_s & prev_q[DMCP_SYN_SCL];
  assign sel_rise = sel_s & ~prev_q[DMCP_SYN_SEL];
  // Data edges only count while the clock stayed high
  assign start_det = scl_s & prev_q[DMCP_SYN_SCL] & prev_q[DMCP_SYN_SDA]
                     & ~sda_s;
  assign stop_det = scl_s & prev_q[DMCP_SYN_SCL] & ~prev_q[DMCP_SYN_SDA]
                    & sda_s;

  // ***********************************************************
  // 3-wire receiver
  // ***********************************************************
  logic [15:0] sr3_q;
  logic [4:0] cnt3_q;
  logic commit_3w;

  // Only the last 16 bits survive if the host clocks extra ones.
  // The count is kept across the select fall, since the word is
  // clocked in before the latch pulse, and cleared by the latch.
  // A clock edge in the cycle the mode takes hold (as after reset,
  // when the pins rise out of the cleared synchroniser) is ignored.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr3_q <= DMCP_WORD_RST;
      cnt3_q <= '0;
    end else if (!mode_3w || !prev_q[DMCP_SYN_MODE]) begin
      cnt3_q <= '0;
    end else if (scl_rise) begin
      sr3_q <= {sr3_q[14:0], sda_s};
      if (cnt3_q != DMCP_3W_FULL) begin
        cnt3_q <= cnt3_q + 5'h01;
      end
    end else if (sel_rise) begin
      cnt3_q <= '0;
    end
  end

  assign commit_3w = mode_3w & sel_rise & (cnt3_q == DMCP_3W_FULL);

  // ***********************************************************
  // 2-wire receiver
  // ***********************************************************
  dmcp_state_t st_q;
  logic [6:0] sh_q;
  logic [2:0] bit_q;
  logic ack_on_q;
  logic [7:0] adr_q, hi_q, lo_q;
  logic [6:0] dev_addr;
  logic [7:0] byte_in;
  logic byte_done, commit_2w, in_byte;

  assign dev_addr = {DMCP_DEV_ADDR_HI, sel_s};
  assign byte_in = {sh_q, sda_s};
  assign in_byte = (st_q == DMCP_ADDR) || (st_q == DMCP_BYTE1) ||
                   (st_q == DMCP_BYTE2);
  assign byte_done = in_byte & scl_rise & (bit_q == DMCP_LAST_BIT);
  assign commit_2w = (st_q == DMCP_ACK_2) & scl_fall & ack_on_q;

  // Bit shifter, msb first, restarted for every byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '0;
      bit_q <= '0;
    end else if (!in_byte) begin
      bit_q <= '0;
    end else if (scl_rise) begin
      sh_q <= byte_in[6:0];
      bit_q <= bit_q + 3'h1;
    end
  end

  // Received bytes; bytes map onto word bits 15..8 and 7..0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adr_q <= DMCP_BYTE_RST;
      hi_q <= DMCP_BYTE_RST;
      lo_q <= DMCP_BYTE_RST;
    end else if (byte_done) begin
      unique case (st_q)
        DMCP_ADDR: adr_q <= byte_in;
        DMCP_BYTE1: hi_q <= byte_in;
        DMCP_BYTE2: lo_q <= byte_in;
        default: adr_q <= adr_q;
      endcase
    end
  end

  // Sequence control; a start in the middle aborts instead of
  // restarting, so the host must send a fresh start afterwards
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DMCP_IDLE;
    end else if (mode_3w) begin
      st_q <= DMCP_IDLE;
    end else if (start_det) begin
      st_q <= (st_q == DMCP_IDLE) ? DMCP_ADDR : DMCP_IDLE;
    end else if (stop_det) begin
      st_q <= DMCP_IDLE;
    end else begin
      unique case (st_q)
        DMCP_IDLE: st_q <= DMCP_IDLE;
        DMCP_ADDR: begin
          if (byte_done) begin
            if (byte_in[7:1] == dev_addr && byte_in[0] == DMCP_DIR_WRITE) begin
              st_q <= DMCP_ACK_A;
            end else begin
              st_q <= DMCP_IDLE;
            end
          end
        end
        DMCP_ACK_A: if (scl_fall && ack_on_q) st_q <= DMCP_BYTE1;
        DMCP_BYTE1: if (byte_done) st_q <= DMCP_ACK_1;
        DMCP_ACK_1: if (scl_fall && ack_on_q) st_q <= DMCP_BYTE2;
        DMCP_BYTE2: if (byte_done) st_q <= DMCP_ACK_2;
        DMCP_ACK_2: if (commit_2w) st_q <= DMCP_WAIT_STOP;
        DMCP_WAIT_STOP: st_q <= DMCP_WAIT_STOP;
      endcase
    end
  end

  // Acknowledge: pull low from the fall after the 8th bit to the
  // next fall, so the host samples it on the ninth clock high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_on_q <= 1'b0;
    end else if (mode_3w || start_det || stop_det) begin
      ack_on_q <= 1'b0;
    end else if (scl_fall) begin
      ack_on_q <= ~ack_on_q & ((st_q == DMCP_ACK_A) ||
                  (st_q == DMCP_ACK_1) || (st_q == DMCP_ACK_2));
    end
  end

  // Open-drain data line: only ever pulled low, no clock output
  assign control_data_line_o = 1'b0;
  assign control_data_line_oe = ack_on_q;

  // ***********************************************************
  // Word output
  // ***********************************************************
  // Top seven bits address the register, low nine are its contents
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= dmcp_word_t'(DMCP_WORD_RST);
      word_valid_q <= 1'b0;
    end else begin
      word_valid_q <= commit_3w | commit_2w;
      if (commit_3w) begin
        word_q <= dmcp_word_t'(sr3_q);
      end else if (commit_2w) begin
        word_q <= dmcp_word_t'({hi_q, lo_q});
      end
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  property p_oe_2w_only;
    @(posedge sys_clk) disable iff (!rst_n)
    control_data_line_oe |-> !mode_3w;
  endproperty
  a_oe_2w_only: assert property (p_oe_2w_only)
    else $error("data line driven in 3-wire format");

  property p_low_only;
    @(posedge sys_clk) disable iff (!rst_n)
    control_data_line_oe |-> control_data_line_o == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("data line driven high");

  property p_ack_match;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(control_data_line_oe) && st_q == DMCP_ACK_A |->
      adr_q[7:1] == dev_addr && adr_q[0] == 1'b0;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("address acknowledged without match");

  property p_nack_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    byte_done && st_q == DMCP_ADDR && !start_det && !stop_det &&
      (byte_in[7:1] != dev_addr || byte_in[0]) |=>
      st_q == DMCP_IDLE && !control_data_line_oe [*2];
  endproperty
  a_nack_idle: assert property (p_nack_idle)
    else $error("wrong address or read not refused");

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n)
    start_det && st_q != DMCP_IDLE |=> st_q == DMCP_IDLE && !word_valid_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("out of sequence start did not abort");

  property p_stop_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    stop_det |=> st_q == DMCP_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to idle");

  property p_addr_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    dev_addr == (sel_s ? 7'h1b : 7'h1a);
  endproperty
  a_addr_sel: assert property (p_addr_sel)
    else $error("device address wrong for select pin");

  property p_3w_word;
    @(posedge sys_clk) disable iff (!rst_n)
    commit_3w |=> word_valid_q && word_q == dmcp_word_t'($past(sr3_q));
  endproperty
  a_3w_word: assert property (p_3w_word)
    else $error("3-wire word not applied on latch");

  property p_complete_only;
    @(posedge sys_clk) disable iff (!rst_n)
    word_valid_q |-> ($past(st_q) == DMCP_ACK_2 && !$past(mode_3w)) ||
      ($past(mode_3w) && $past(cnt3_q) == DMCP_3W_FULL);
  endproperty
  a_complete_only: assert property (p_complete_only)
    else $error("word applied from incomplete transfer");

  property p_2w_bytes;
    @(posedge sys_clk) disable iff (!rst_n)
    commit_2w |=> word_q == dmcp_word_t'({$past(hi_q), $past(lo_q)});
  endproperty
  a_2w_bytes: assert property (p_2w_bytes)
    else $error("2-wire bytes assembled wrongly");

endmodule
`default_nettype wire

/* rtl/dmcp_sync2.sv */
// Two flip-flop synchroniser for the serial port pins
`timescale 1ns/100ps
`default_nettype none
module dmcp_sync2
  import dmcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);

  logic [3:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= DMCP_SYN_RST;
      sync_out <= DMCP_SYN_RST;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* verif/dmcp_host.sv */
// Host model: serial bus master for the 2-wire and 3-wire control port
`timescale 1ns/100ps
`default_nettype none
module dmcp_host (
  input wire logic sys_clk,
  input wire logic dev_oe,
  output logic scl,
  output logic sda,
  output logic sel
);
  logic sda_drv;
  int slow;

  // Pulled-up data wire: low while either party pulls it
  assign sda = sda_drv & ~dev_oe;

  // Clock stands high between 2-wire frames, so no stray edge reaches the port; 3-wire frames leave it low
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    sel = 1'b1;
    slow = 0;
  end

  // *****
  // Bit level
  // *****
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Data moves only while the clock is low; slow stretches the low phase
  task automatic put_bit(input logic b, output logic seen);
    cyc(2 + slow);
    sda_drv <= b;
    cyc(2);
    scl <= 1'b1;
    cyc(2);
    seen = sda;
    cyc(2);
    scl <= 1'b0;
  endtask

  // *****
  // 2-wire frames
  // *****
  // Data raised first, so a start in mid-frame is a clean start too
  task automatic start();
    sda_drv <= 1'b1;
    cyc(4);
    scl <= 1'b1;
    cyc(4);
    sda_drv <= 1'b0;
    cyc(4);
    scl <= 1'b0;
  endtask

  task automatic stop();
    sda_drv <= 1'b0;
    cyc(4);
    scl <= 1'b1;
    cyc(4);
    sda_drv <= 1'b1;
    cyc(6);
  endtask

  // Eight bits msb first, then the wire released for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic tw_write(input logic [6:0] ad, input logic rw,
                          input logic [15:0] w, output logic [2:0] acks);
    start();
    send_byte({ad, rw}, acks[2]);
    send_byte(w[15:8], acks[1]);
    send_byte(w[7:0], acks[0]);
    stop();
  endtask

  // *****
  // 3-wire frames
  // *****
  // Bit n-1 first; the low pulse on select latches the word.
  // Clock parked low first so the first bit gets its own rising edge
  task automatic three(input logic [16:0] w, input int n);
    logic s;
    sel <= 1'b1;
    scl <= 1'b0;
    cyc(4);
    for (int i = n - 1; i >= 0; i--) begin
      put_bit(w[i], s);
    end
    cyc(4);
    sel <= 1'b0;
    cyc(4);
    sel <= 1'b1;
    cyc(8);
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking testbench of the dual mode control port
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dmcp_pkg::*;
  logic sys_clk, rst_n, fmt, scl, sda, sel, dout, doe, wvalid;
  dmcp_word_t word;
  logic [15:0] last;
  int err_count, compares, pulses, oe3w;

  dmcp_port i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .format_sel_pin(fmt),
    .serial_clk(scl), .control_data_line_i(sda), .control_data_line_o(dout),
    .control_data_line_oe(doe), .select_latch_or_addr_pin(sel),
    .word_q(word), .word_valid_q(wvalid));
  dmcp_host i_host (.sys_clk(sys_clk), .dev_oe(doe), .scl(scl), .sda(sda),
    .sel(sel));

  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Record applied words; an acknowledge in 3-wire format is a fault
  always @(posedge sys_clk) begin
    if (wvalid === 1'b1) begin
      pulses++;
      last = word;
    end
    if (fmt === 1'b1 && doe !== 1'b0) oe3w++;
  end

  // *****
  // Checking
  // *****
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // *****
  // Scenarios
  // *****
  task automatic good_write(input logic s, input logic [15:0] w);
    logic [2:0] a;
    int p;
    p = pulses;
    i_host.sel <= s;
    i_host.tw_write({6'b001101, s}, 1'b0, w, a);
    chk("acks", 16'h0007, {13'h0, a});
    chk("pulse", 16'(p + 1), 16'(pulses));
    chk("word", w, last);
    chk("addr", {9'h0, w[15:9]}, {9'h0, word.addr});
  endtask

  task automatic bad_write(input logic s, input logic [6:0] ad,
                           input logic rw);
    logic [2:0] a;
    int p;
    p = pulses;
    i_host.sel <= s;
    i_host.tw_write(ad, rw, 16'h1234, a);
    chk("nack", 16'h0000, {13'h0, a});
    chk("pulse", 16'(p), 16'(pulses));
  endtask

  task automatic t_reset();
    chk("oe", 16'h0000, {15'h0, doe});
    chk("dout", 16'h0000, {15'h0, dout});
    chk("word", 16'h0000, word);
    chk("pulse", 16'h0000, 16'(pulses));
  endtask

  // Slow host in the middle; open strap modelled as a low level
  task automatic t_tw_ok();
    good_write(1'b0, 16'h8001);
    good_write(1'b1, 16'h7ffe);
    i_host.slow = 6;
    good_write(1'b1, 16'hffff);
    i_host.slow = 0;
    good_write(1'b0, 16'h0000);
  endtask

  task automatic t_tw_nack();
    bad_write(1'b0, 7'b0011011, 1'b0);
    bad_write(1'b1, 7'b0011010, 1'b0);
    bad_write(1'b0, 7'b0011010, 1'b1);
    bad_write(1'b0, 7'b0111010, 1'b0);
  endtask

  // Stop after one data byte, then a start in mid-frame
  task automatic t_abort();
    logic a;
    int p;
    p = pulses;
    i_host.sel <= 1'b0;
    i_host.start();
    i_host.send_byte(8'h34, a);
    i_host.send_byte(8'hc3, a);
    i_host.stop();
    i_host.start();
    i_host.send_byte(8'h34, a);
    i_host.start();
    i_host.send_byte(8'hc3, a);
    chk("ack", 16'h0000, {15'h0, a});
    i_host.stop();
    chk("pulse", 16'(p), 16'(pulses));
    good_write(1'b0, 16'h2b6d);
  endtask

  // Exact, short and long frames, then back to 2-wire
  task automatic t_three();
    int p;
    fmt <= 1'b1;
    i_host.cyc(6);
    p = pulses;
    i_host.three(17'h0c35a, 16);
    chk("pulse", 16'(p + 1), 16'(pulses));
    chk("word", 16'hc35a, last);
    i_host.three(17'h01111, 15);
    chk("pulse", 16'(p + 1), 16'(pulses));
    i_host.three(17'h1a5f0, 17);
    chk("word", 16'ha5f0, last);
    chk("pulse", 16'(p + 2), 16'(pulses));
    chk("oe3w", 16'h0000, 16'(oe3w));
    fmt <= 1'b0;
    i_host.cyc(6);
    good_write(1'b1, 16'h4c2d);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    fmt = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_tw_ok();
    t_tw_nack();
    t_abort();
    t_three();
    finish_test();
  end

  // Watchdog: the run needs well under 10000 cycles
  initial begin
    #1000000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
